// *** src/pgrc_top.sv ***
// PWM output gating, run control and capture readout with AXI4-Lite slave
// Contract
// - Separate enable per pin per submodule
// - All pin enables in one register
// - Separate mask per pin, one register
// - Masks buffered, applied on force or update
// - Software update copies submodule mask immediately
// - Debug run setting keeps or halts submodule
// - Wait run setting keeps or halts submodule
// - Run bits gate submodules, start together
// - Clearing run resets counter, multi-stop
// - Capture event stores counter into capture value
// - Capture cycle register holds matching cycle
// - Cycle number increments on each reload
// - Software force only when source is software
`timescale 1ns/100ps

module pgrc_top (
	// Clock, reset, enable
	input  wire logic                         clk_in,
	input  wire logic                         rst_in,
	input  wire logic                         ce_in,
	// AXI4-Lite write address
	input  wire logic [pgrc_pkg::ADDR_W-1:0]  s_axi_awaddr_in,
	input  wire logic                         s_axi_awvalid_in,
	output logic                              s_axi_awready_out,
	// AXI4-Lite write data
	input  wire logic [pgrc_pkg::DATA_W-1:0]  s_axi_wdata_in,
	input  wire logic [3:0]                   s_axi_wstrb_in,
	input  wire logic                         s_axi_wvalid_in,
	output logic                              s_axi_wready_out,
	// AXI4-Lite write response
	output logic [1:0]                        s_axi_bresp_out,
	output logic                              s_axi_bvalid_out,
	input  wire logic                         s_axi_bready_in,
	// AXI4-Lite read address
	input  wire logic [pgrc_pkg::ADDR_W-1:0]  s_axi_araddr_in,
	input  wire logic                         s_axi_arvalid_in,
	output logic                              s_axi_arready_out,
	// AXI4-Lite read data
	output logic [pgrc_pkg::DATA_W-1:0]       s_axi_rdata_out,
	output logic [1:0]                        s_axi_rresp_out,
	output logic                              s_axi_rvalid_out,
	input  wire logic                         s_axi_rready_in,
	// Chip mode and event inputs
	input  wire logic                         debug_mode_in,
	input  wire logic                         wait_mode_in,
	input  wire logic [pgrc_pkg::NSM-1:0]     capture_in,
	input  wire logic [pgrc_pkg::NSM-1:0]     force_in,
	// Output pins
	output logic [pgrc_pkg::NSM-1:0]          first_pin_out,
	output logic [pgrc_pkg::NSM-1:0]          first_pin_oe_out,
	output logic [pgrc_pkg::NSM-1:0]          second_pin_out,
	output logic [pgrc_pkg::NSM-1:0]          second_pin_oe_out,
	output logic [pgrc_pkg::NSM-1:0]          aux_pin_out,
	output logic [pgrc_pkg::NSM-1:0]          aux_pin_oe_out
);
	import pgrc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Byte-lane merge onto a 16-bit register
	function automatic logic [REG_W-1:0] wr16(
		input logic [REG_W-1:0]  old,
		input logic [DATA_W-1:0] data,
		input logic [3:0]        strb
	);
		wr16 = old;
		if (strb[0]) begin
			wr16[7:0] = data[7:0];
		end
		if (strb[1]) begin
			wr16[15:8] = data[15:8];
		end
	endfunction

	// Word-aligned address of array element i
	function automatic logic [ADDR_W-1:0] elem_addr(
		input logic [ADDR_W-1:0] base,
		input int                i
	);
		elem_addr = base + ADDR_W'(i) * REG_STRIDE;
	endfunction

	// Whether an address hits a register
	function automatic logic reg_known(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] al;
		al = {a[ADDR_W-1:2], 2'b00};
		reg_known = (al == OFS_OUTPUT_ENABLE_CONTROL) || (al == OFS_MASK) ||
			(al == OFS_RUN) || (al == OFS_CMD) || (al == OFS_FSEL) ||
			(al == OFS_MASK_ACT);
		for (int i = 0; i < NSM; i++) begin
			if ((al == elem_addr(OFS_PERIOD, i)) ||
				(al == elem_addr(OFS_DUTY, i)) ||
				(al == elem_addr(OFS_CAPVAL, i)) ||
				(al == elem_addr(OFS_CAPCYC, i))) begin
				reg_known = 1'b1;
			end
		end
	endfunction

	// Read data for an address, zero above the register width
	function automatic logic [DATA_W-1:0] reg_read(
		input pgrc_state_s       s,
		input logic [ADDR_W-1:0] a
	);
		logic [ADDR_W-1:0] al;
		logic [REG_W-1:0]  v;
		al = {a[ADDR_W-1:2], 2'b00};
		v = '0;
		if (al == OFS_OUTPUT_ENABLE_CONTROL) begin
			v = s.output_enable_control;
		end
		if (al == OFS_MASK) begin
			v = s.mask_buf;
		end
		if (al == OFS_RUN) begin
			v = s.run_ctl;
		end
		if (al == OFS_FSEL) begin
			v = REG_W'(s.force_sel);
		end
		if (al == OFS_MASK_ACT) begin
			v = s.mask_act;
		end
		for (int i = 0; i < NSM; i++) begin
			if (al == elem_addr(OFS_PERIOD, i)) begin
				v = s.period[i];
			end
			if (al == elem_addr(OFS_DUTY, i)) begin
				v = s.duty[i];
			end
			if (al == elem_addr(OFS_CAPVAL, i)) begin
				v = s.cap_val[i];
			end
			if (al == elem_addr(OFS_CAPCYC, i)) begin
				v = s.cap_cyc[i];
			end
		end
		reg_read = {{(DATA_W-REG_W){1'b0}}, v};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state

	pgrc_state_s s_q;
	pgrc_state_s s_d;

	always_comb begin
		logic [ADDR_W-1:0] al;
		logic [NSM-1:0]    upd;
		logic [NSM-1:0]    sw_frc;
		logic              halted;
		logic              fevt;
		logic              pwm;
		al = {s_q.awaddr[ADDR_W-1:2], 2'b00};
		upd = '0;
		sw_frc = '0;
		halted = 1'b0;
		fevt = 1'b0;
		pwm = 1'b0;
		s_d = s_q;

		// Write address and data taken in either order
		if (s_axi_awvalid_in && s_q.awready) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_q.wready) begin
			s_d.w_held = 1'b1;
			s_d.wdata = s_axi_wdata_in;
			s_d.wstrb = s_axi_wstrb_in;
		end

		// Register write once both halves are held
		if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = reg_known(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (al == OFS_OUTPUT_ENABLE_CONTROL) begin
				s_d.output_enable_control = wr16(s_q.output_enable_control, s_q.wdata, s_q.wstrb);
			end
			if (al == OFS_MASK) begin
				s_d.mask_buf = wr16(s_q.mask_buf, s_q.wdata,
					s_q.wstrb);
			end
			if (al == OFS_RUN) begin
				s_d.run_ctl = wr16(s_q.run_ctl, s_q.wdata, s_q.wstrb);
			end
			if (al == OFS_FSEL) begin
				s_d.force_sel = NSM'(wr16(REG_W'(s_q.force_sel),
					s_q.wdata, s_q.wstrb));
			end
			if ((al == OFS_CMD) && s_q.wstrb[0]) begin
				upd = s_q.wdata[CMD_UPD_LSB +: NSM];
				sw_frc = s_q.wdata[CMD_FRC_LSB +: NSM];
			end
			for (int i = 0; i < NSM; i++) begin
				if (al == elem_addr(OFS_PERIOD, i)) begin
					s_d.period[i] = wr16(s_q.period[i], s_q.wdata,
						s_q.wstrb);
				end
				if (al == elem_addr(OFS_DUTY, i)) begin
					s_d.duty[i] = wr16(s_q.duty[i], s_q.wdata, s_q.wstrb);
				end
			end
		end
		if (s_q.bvalid && s_axi_bready_in) begin
			s_d.bvalid = 1'b0;
		end
		s_d.awready = !s_d.aw_held && !s_d.bvalid;
		s_d.wready = !s_d.w_held && !s_d.bvalid;

		// Read channel
		if (s_axi_arvalid_in && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = reg_read(s_q, s_axi_araddr_in);
			s_d.rresp = reg_known(s_axi_araddr_in) ? RESP_OKAY
				: RESP_SLVERR;
		end else if (s_q.rvalid && s_axi_rready_in) begin
			s_d.rvalid = 1'b0;
		end
		s_d.arready = !s_d.rvalid;

		// Per-submodule counter, capture, mask and pins
		for (int i = 0; i < NSM; i++) begin
			halted = (debug_mode_in && !s_d.run_ctl[DBGRUN_LSB+i]) ||
				(wait_mode_in && !s_d.run_ctl[WAITRUN_LSB+i]);
			if (!s_d.run_ctl[RUN_LSB+i]) begin
				s_d.cnt[i] = '0;
				s_d.cyc[i] = '0;
			end else if (!halted) begin
				if (s_q.cnt[i] >= s_q.period[i]) begin
					s_d.cnt[i] = '0;
					s_d.cyc[i] = s_q.cyc[i] + 16'h0001;
				end else begin
					s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
				end
			end

			if (capture_in[i] && s_q.run_ctl[RUN_LSB+i]) begin
				s_d.cap_val[i] = s_q.cnt[i];
				s_d.cap_cyc[i] = s_q.cyc[i];
			end

			// Force source chosen per submodule
			fevt = s_q.force_sel[i] ? sw_frc[i] : force_in[i];
			if (fevt || upd[i]) begin
				s_d.mask_act[FLD_A_LSB+i] = s_d.mask_buf[FLD_A_LSB+i];
				s_d.mask_act[FLD_B_LSB+i] = s_d.mask_buf[FLD_B_LSB+i];
				s_d.mask_act[FLD_X_LSB+i] = s_d.mask_buf[FLD_X_LSB+i];
			end

			pwm = s_q.run_ctl[RUN_LSB+i] && (s_q.cnt[i] < s_q.duty[i]);
			s_d.first_pin[i] = pwm && !s_q.mask_act[FLD_A_LSB+i];
			s_d.second_pin[i] = s_q.run_ctl[RUN_LSB+i] && !pwm &&
				!s_q.mask_act[FLD_B_LSB+i];
			s_d.aux_pin[i] = pwm && !s_q.mask_act[FLD_X_LSB+i];
			s_d.first_oe[i] = s_q.output_enable_control[FLD_A_LSB+i];
			s_d.second_oe[i] = s_q.output_enable_control[FLD_B_LSB+i];
			s_d.aux_oe[i] = s_q.output_enable_control[FLD_X_LSB+i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
			s_q.period <= {NSM{PERIOD_RST}};
			s_q.duty <= {NSM{DUTY_RST}};
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign s_axi_awready_out = s_q.awready;
	assign s_axi_wready_out = s_q.wready;
	assign s_axi_bresp_out = s_q.bresp;
	assign s_axi_bvalid_out = s_q.bvalid;
	assign s_axi_arready_out = s_q.arready;
	assign s_axi_rdata_out = s_q.rdata;
	assign s_axi_rresp_out = s_q.rresp;
	assign s_axi_rvalid_out = s_q.rvalid;
	assign first_pin_out = s_q.first_pin;
	assign first_pin_oe_out = s_q.first_oe;
	assign second_pin_out = s_q.second_pin;
	assign second_pin_oe_out = s_q.second_oe;
	assign aux_pin_out = s_q.aux_pin;
	assign aux_pin_oe_out = s_q.aux_oe;

endmodule

// *** src/pgrc_pkg.sv ***
// Shared constants and state type for the PWM gating and capture block
package pgrc_pkg;

	// Widths and submodule count
	localparam int NSM    = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_ENABLE_CONTROL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MASK     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RUN      = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CMD      = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_FSEL     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK_ACT = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PERIOD   = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_DUTY     = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_CAPVAL   = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_CAPCYC   = 8'h50;
	localparam logic [ADDR_W-1:0] REG_STRIDE   = 8'h04;

	// Field positions: pin groups in enable and mask registers
	localparam int FLD_X_LSB = 0;
	localparam int FLD_B_LSB = 4;
	localparam int FLD_A_LSB = 8;

	// Field positions: run control and command registers
	localparam int RUN_LSB     = 0;
	localparam int DBGRUN_LSB  = 4;
	localparam int WAITRUN_LSB = 8;
	localparam int CMD_UPD_LSB = 0;
	localparam int CMD_FRC_LSB = 4;

	// Reset values
	localparam logic [REG_W-1:0] PERIOD_RST = 16'h00FF;
	localparam logic [REG_W-1:0] DUTY_RST   = 16'h0080;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// All state of the block
	typedef struct packed {
		logic                       awready;
		logic                       wready;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [1:0]                 rresp;
		logic [DATA_W-1:0]          rdata;
		logic                       aw_held;
		logic                       w_held;
		logic [ADDR_W-1:0]          awaddr;
		logic [DATA_W-1:0]          wdata;
		logic [3:0]                 wstrb;
		logic [REG_W-1:0]           output_enable_control;
		logic [REG_W-1:0]           mask_buf;
		logic [REG_W-1:0]           mask_act;
		logic [REG_W-1:0]           run_ctl;
		logic [NSM-1:0]             force_sel;
		logic [NSM-1:0][REG_W-1:0]  period;
		logic [NSM-1:0][REG_W-1:0]  duty;
		logic [NSM-1:0][REG_W-1:0]  cnt;
		logic [NSM-1:0][REG_W-1:0]  cyc;
		logic [NSM-1:0][REG_W-1:0]  cap_val;
		logic [NSM-1:0][REG_W-1:0]  cap_cyc;
		logic [NSM-1:0]             first_pin;
		logic [NSM-1:0]             second_pin;
		logic [NSM-1:0]             aux_pin;
		logic [NSM-1:0]             first_oe;
		logic [NSM-1:0]             second_oe;
		logic [NSM-1:0]             aux_oe;
	} pgrc_state_s;

endpackage

// *** bench/pgrc_monitor.sv ***
// Handshake and pin relation checks for the gating block
`timescale 1ns/100ps
module pgrc_monitor (
	// Clock and reset
	input wire logic			clk_in,
	input wire logic			rst_in,
	// Write side
	input wire logic			s_axi_awvalid_in,
	input wire logic			s_axi_awready_out,
	input wire logic			s_axi_wvalid_in,
	input wire logic			s_axi_wready_out,
	input wire logic [1:0]			s_axi_bresp_out,
	input wire logic			s_axi_bvalid_out,
	input wire logic			s_axi_bready_in,
	// Read side
	input wire logic			s_axi_arvalid_in,
	input wire logic			s_axi_arready_out,
	input wire logic [pgrc_pkg::DATA_W-1:0]	s_axi_rdata_out,
	input wire logic			s_axi_rvalid_out,
	input wire logic			s_axi_rready_in,
	// Pins
	input wire logic [pgrc_pkg::NSM-1:0]	first_pin_out,
	input wire logic [pgrc_pkg::NSM-1:0]	second_pin_out,
	input wire logic [pgrc_pkg::NSM-1:0]	first_pin_oe_out,
	input wire logic [pgrc_pkg::NSM-1:0]	second_pin_oe_out,
	input wire logic [pgrc_pkg::NSM-1:0]	aux_pin_oe_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////////
	sequence s_wr_take;
		s_axi_awvalid_in && s_axi_awready_out &&
		s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	////////////////////////////////////////////////////////////////////
	AST_WR_LATENCY: assert property (s_wr_take |=>
		!s_axi_bvalid_out ##1 s_axi_bvalid_out)
		else $error("write answer not after two edges");
	AST_WR_BUSY: assert property (s_wr_take |=>
		(!s_axi_awready_out && !s_axi_wready_out)[*2])
		else $error("write ready during write");
	AST_WR_FREE: assert property (s_axi_bvalid_out && s_axi_bready_in
		|=> s_axi_awready_out && s_axi_wready_out)
		else $error("write ready not back");
	AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write answer dropped");
	AST_RD_LATENCY: assert property (s_rd_take |=>
		s_axi_rvalid_out && !s_axi_arready_out)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped");
	AST_RD_FREE: assert property (s_axi_rvalid_out && s_axi_rready_in
		|=> !s_axi_rvalid_out && s_axi_arready_out)
		else $error("read not released");
	AST_OE_BY_WRITE: assert property ($changed({first_pin_oe_out,
		second_pin_oe_out, aux_pin_oe_out}) |-> $past(s_axi_bvalid_out))
		else $error("enable changed without write");
	AST_PIN_EXCL: assert property (
		(first_pin_out & second_pin_out) == 4'h0)
		else $error("both pins high");
endmodule

// *** bench/pgrc_top_tb.sv ***
// Register-level bench for the gating, run and capture block
`timescale 1ns/100ps
module pgrc_top_tb;
	import pgrc_pkg::*;
	logic			clk_in = '0, rst_in = '1, ce_in = '1;
	logic [ADDR_W-1:0]	s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
	logic [DATA_W-1:0]	s_axi_wdata_in = '0, s_axi_rdata_out;
	logic [3:0]		s_axi_wstrb_in = '1, capture_in = '0, force_in = '0;
	logic			s_axi_awvalid_in = '0, s_axi_wvalid_in = '0;
	logic			s_axi_bready_in = '0, s_axi_arvalid_in = '0;
	logic			s_axi_rready_in = '0, debug_mode_in = '0;
	logic			wait_mode_in = '0, s_axi_awready_out;
	logic			s_axi_wready_out, s_axi_bvalid_out;
	logic			s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0]		s_axi_bresp_out, s_axi_rresp_out;
	logic [NSM-1:0]		first_pin_out, first_pin_oe_out, second_pin_out;
	logic [NSM-1:0]		second_pin_oe_out, aux_pin_out, aux_pin_oe_out;
	logic [31:0]		v0, c0, v1, c1, d;
	int			num_errors = 0, num_checks = 0;
	always #20 clk_in = ~clk_in;
	pgrc_top pgrc_top_inst (.*);
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chkr(input logic [1:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: resp %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] r);
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= v;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
		end while (s_axi_bvalid_out !== 1'h1);
		s_axi_bready_in <= 1'h0;
		chkr(s_axi_bresp_out, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		input logic [1:0] r);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
		end while (s_axi_rvalid_out !== 1'h1);
		s_axi_rready_in <= 1'h0;
		v = s_axi_rdata_out;
		chkr(s_axi_rresp_out, r);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a, d, RESP_OKAY);
		chk(d, e);
	endtask
	// Captures sm0, then sm1 gap edges later; compares count difference
	// Frz holds clock enable low on every edge in between
	task automatic capd(input int gap, input logic frz,
		input logic [31:0] e);
		@(posedge clk_in);
		capture_in <= (gap != 0) ? 4'h1 : 4'h3;
		@(posedge clk_in);
		capture_in <= 4'h0;
		if (gap != 0) begin
			ce_in <= !frz;
			repeat (gap - 1) @(posedge clk_in);
			ce_in <= 1'h1;
			capture_in <= 4'h2;
			@(posedge clk_in);
			capture_in <= 4'h0;
		end
		rd(OFS_CAPVAL, v0, RESP_OKAY);
		rd(OFS_CAPCYC, c0, RESP_OKAY);
		rd(OFS_CAPVAL + REG_STRIDE, v1, RESP_OKAY);
		rd(OFS_CAPCYC + REG_STRIDE, c1, RESP_OKAY);
		chk(v1 + 32'h100 * c1 - v0 - 32'h4 * c0, e);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_in);
		rst_in <= 1'h0;
		repeat (2) @(posedge clk_in);
		wr(OFS_OUTPUT_ENABLE_CONTROL, 32'h0421, RESP_OKAY);
		rc(OFS_OUTPUT_ENABLE_CONTROL, 32'h0421);
		chk(32'({first_pin_oe_out, second_pin_oe_out, aux_pin_oe_out}),
			32'h0421);
		wr(8'h18, 32'h1, RESP_SLVERR);
		rd(8'h18, d, RESP_SLVERR);
		chk(d, 32'h0);
		$display("test enables done");
		wr(OFS_MASK, 32'h0F0F, RESP_OKAY);
		rc(OFS_MASK, 32'h0F0F);
		rc(OFS_MASK_ACT, 32'h0);
		wr(OFS_CMD, 32'h1, RESP_OKAY);
		rc(OFS_MASK_ACT, 32'h0101);
		@(posedge clk_in);
		force_in <= 4'h2;
		@(posedge clk_in);
		force_in <= 4'h0;
		rc(OFS_MASK_ACT, 32'h0303);
		wr(OFS_CMD, 32'h40, RESP_OKAY);
		rc(OFS_MASK_ACT, 32'h0303);
		wr(OFS_FSEL, 32'h4, RESP_OKAY);
		wr(OFS_CMD, 32'h40, RESP_OKAY);
		wr(OFS_MASK_ACT, 32'h0, RESP_OKAY);
		rc(OFS_MASK_ACT, 32'h0707);
		chk(32'({first_pin_oe_out, second_pin_oe_out, aux_pin_oe_out}),
			32'h0421);
		$display("test masks done");
		wr(OFS_PERIOD, 32'h3, RESP_OKAY);
		wr(OFS_DUTY, 32'h2, RESP_OKAY);
		wr(OFS_RUN, 32'h3, RESP_OKAY);
		capd(10, 1'h0, 32'hA);
		d = '0;
		repeat (40) begin
			@(posedge clk_in);
			d[1] = d[1] | first_pin_out[0] | aux_pin_out[0];
			d[0] = d[0] | second_pin_out[0];
		end
		chk(d, 32'h1);
		$display("test run done");
		wr(OFS_RUN, 32'h23, RESP_OKAY);
		@(posedge clk_in);
		debug_mode_in <= 1'h1;
		repeat (20) @(posedge clk_in);
		debug_mode_in <= 1'h0;
		capd(0, 1'h0, 32'h14);
		wr(OFS_RUN, 32'h103, RESP_OKAY);
		@(posedge clk_in);
		wait_mode_in <= 1'h1;
		repeat (15) @(posedge clk_in);
		wait_mode_in <= 1'h0;
		capd(0, 1'h0, 32'h5);
		wr(OFS_RUN, 32'h0, RESP_OKAY);
		wr(OFS_RUN, 32'h3, RESP_OKAY);
		capd(0, 1'h0, 32'h0);
		$display("test modes done");
		wr(OFS_MASK, 32'h0, RESP_OKAY);
		wr(OFS_CMD, 32'h1, RESP_OKAY);
		d = '0;
		repeat (8) begin
			@(posedge clk_in);
			d[1] = d[1] | (first_pin_out[0] & aux_pin_out[0]);
			d[0] = d[0] | (first_pin_out[0] & second_pin_out[0]);
		end
		chk(d, 32'h2);
		capd(10, 1'h1, 32'h1);
		$display("test unmask and freeze done");
		end_sim;
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		num_errors++;
		end_sim;
	end
endmodule
bind pgrc_top pgrc_monitor pgrc_monitor_inst (.*);
